// ==== inc/osc_ctrl_pkg.sv ====
// Operation
// - Report active source in read-only field
// - Requested source writable, reset from configuration
// - Switch request bit clears when switch completes
// - Oscillator register writes need unlock sequence
// - Freeze plus monitor bit blocks clock changes
// - Lock status shows locked or timer expired
// - Clock fail flag set by monitor, software-cleared
// - Software set of fail flag raises trap
// - Recover on interrupt clears doze enable
// - Doze ratio divides by power of two
// - Doze enable applies ratio, else 1:1
// - Doze ratio writes ignored while doze enabled
// - Doze enable cannot be set with ratio zero
// - Fast RC postscaler divides 1 to 256
// - Loop prescaler codes one to eight, reset one
// - Unimplemented divider bits read as zero
package osc_ctrl_pkg;
    localparam logic [31:0] OSC_SELECT_CONTROL_ADDR = 32'h0000_0000;
    localparam logic [31:0] CLOCK_DIVIDER_CONTROL_ADDR = 32'h0000_0004;
    localparam logic [31:0] PLL_FEEDBACK_DIVIDER_ADDR = 32'h0000_0008;
    localparam logic [31:0] UNLOCK_ADDR = 32'h0000_000C;
    localparam logic [15:0] UNLOCK_KEY1 = 16'h0055;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h00AA;
    // Select register fields
    localparam int CUR_LSB = 12;
    localparam int REQ_LSB = 8;
    localparam int FREEZE_BIT = 7;
    localparam int LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int SWREQ_BIT = 0;
    // Divider register fields
    localparam int ROI_BIT = 15;
    localparam int DOZE_LSB = 12;
    localparam int REDUCE_RATIO_ENABLE_BIT = 11;
    localparam int FAST_RC_POSTSCALER_LSB = 8;
    localparam int PRE_LSB = 0;
    localparam logic [2:0] DOZE_RESET = 3'h3;
    localparam logic [2:0] DOZE_ONE = 3'h0;
    localparam logic [2:0] POST_RESET = 3'h0;
    localparam logic [3:0] PRE_RESET = 4'h1;
    localparam logic [3:0] PRE_MIN = 4'h1;
    localparam logic [3:0] PRE_MAX = 4'h8;
    localparam logic [7:0] FBD_RESET = 8'h96;
    localparam logic [2:0] SRC_FAST_RC = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT = 2'b01,
        SW_DONE = 2'b11
    } switch_state_t;
endpackage

// ==== rtl/clock_ratio_divider.sv ====
`timescale 1ns/1ns
// Divides by period_m1 + 1; strobe one clock every period
module clock_ratio_divider
    import osc_ctrl_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [CNT_W-1:0] period_m1,
    output logic tick
);
    logic [CNT_W-1:0] count;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else if (count >= period_m1)
        begin
            count <= '0;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// ==== rtl/secondary_osc_switch_ctrl.sv ====
`timescale 1ns/1ns
module secondary_osc_switch_ctrl
    import osc_ctrl_pkg::*;
#(
    parameter int SWITCH_CYCLES = 16
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] config_source_sel,
    input wire logic monitor_config_bit,
    input wire logic loop_locked,
    input wire logic loop_timer_done,
    input wire logic loop_enabled,
    input wire logic fail_safe_monitor,
    input wire logic irq_event,
    input wire logic source_ready,
    output logic [2:0] active_source,
    output logic osc_fail_trap,
    output logic [2:0] fast_rc_postscaler,
    output logic [3:0] loop_prescaler,
    output logic [7:0] loop_feedback_divisor,
    output logic [2:0] doze_ratio,
    output logic reduce_ratio_enable,
    output logic cpu_clock_tick
);
    logic [2:0] current_source_sel;
    logic [2:0] requested_source_sel;
    logic source_switch_request;
    logic clock_config_freeze;
    logic clock_fail_flag;
    logic recover_on_irq;
    logic [2:0] doze;
    logic [7:0] fbd;
    logic [1:0] unlock_stage;
    logic cfg_loaded;
    logic frozen;
    switch_state_t sw_state;
    logic [7:0] sw_count;
    logic aw_held, w_held;
    logic [31:0] aw_addr, w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [15:0] wd;
    logic wr_osc, wr_div, wr_fbd, wr_key, wr_ok;
    logic lo_en, hi_en;
    logic [7:0] doze_period;
    logic switch_done;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic lo, input logic hi);
        merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
    endfunction

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wd = w_data[15:0];
    assign lo_en = w_strb[0];
    assign hi_en = w_strb[1];
    assign wr_osc = do_write && aw_addr[7:0] == OSC_SELECT_CONTROL_ADDR[7:0];
    assign wr_div = do_write && aw_addr[7:0] == CLOCK_DIVIDER_CONTROL_ADDR[7:0];
    assign wr_fbd = do_write && aw_addr[7:0] == PLL_FEEDBACK_DIVIDER_ADDR[7:0];
    assign wr_key = do_write && aw_addr[7:0] == UNLOCK_ADDR[7:0];
    assign wr_ok = wr_osc || wr_div || wr_fbd || wr_key;
    assign frozen = clock_config_freeze && monitor_config_bit;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Unlock: two key writes, then one write to the select register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            unlock_stage <= 2'd0;
        end
        else if (wr_key)
        begin
            if (unlock_stage == 2'd0 && wd == UNLOCK_KEY1)
            begin
                unlock_stage <= 2'd1;
            end
            else if (unlock_stage == 2'd1 && wd == UNLOCK_KEY2)
            begin
                unlock_stage <= 2'd2;
            end
            else
            begin
                unlock_stage <= 2'd0;
            end
        end
        else if (do_write)
        begin
            unlock_stage <= 2'd0;
        end
    end

    // Select register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_loaded <= 1'b0;
            requested_source_sel <= SRC_FAST_RC;
            current_source_sel <= SRC_FAST_RC;
            source_switch_request <= 1'b0;
            clock_config_freeze <= 1'b0;
        end
        else
        begin
            if (!cfg_loaded)
            begin
                cfg_loaded <= 1'b1;
                requested_source_sel <= config_source_sel;
                current_source_sel <= config_source_sel;
            end
            else if (wr_osc && unlock_stage == 2'd2)
            begin
                if (hi_en && !frozen)
                begin
                    requested_source_sel <= wd[REQ_LSB +: 3];
                end
                if (lo_en)
                begin
                    if (!frozen)
                    begin
                        clock_config_freeze <= wd[FREEZE_BIT];
                    end
                    if (wd[SWREQ_BIT] && !frozen)
                    begin
                        source_switch_request <= 1'b1;
                    end
                end
            end
            if (switch_done)
            begin
                current_source_sel <= requested_source_sel;
                source_switch_request <= 1'b0;
            end
        end
    end

    // Switch sequencer: waits for source ready, then a settle count
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sw_state <= SW_IDLE;
            sw_count <= '0;
        end
        else
        begin
            unique case (sw_state)
                SW_IDLE:
                begin
                    sw_count <= '0;
                    if (source_switch_request)
                    begin
                        sw_state <= SW_WAIT;
                    end
                end
                SW_WAIT:
                begin
                    if (source_ready)
                    begin
                        sw_count <= sw_count + 1'b1;
                    end
                    if (sw_count >= 8'(SWITCH_CYCLES - 1))
                    begin
                        sw_state <= SW_DONE;
                    end
                end
                SW_DONE:
                begin
                    sw_state <= SW_IDLE;
                end
                default:
                begin
                    sw_state <= SW_IDLE;
                end
            endcase
        end
    end
    assign switch_done = sw_state == SW_DONE;

    // Fail flag: monitor set wins over software clear
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clock_fail_flag <= 1'b0;
            osc_fail_trap <= 1'b0;
        end
        else
        begin
            if (fail_safe_monitor)
            begin
                clock_fail_flag <= 1'b1;
            end
            else if (wr_osc && unlock_stage == 2'd2 && lo_en)
            begin
                clock_fail_flag <= wd[FAIL_BIT];
            end
            osc_fail_trap <= fail_safe_monitor ||
                (wr_osc && unlock_stage == 2'd2 && lo_en && wd[FAIL_BIT]);
        end
    end

    // Divider register and feedback divisor
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            recover_on_irq <= 1'b0;
            doze <= DOZE_RESET;
            reduce_ratio_enable <= 1'b0;
            fast_rc_postscaler <= POST_RESET;
            loop_prescaler <= PRE_RESET;
            fbd <= FBD_RESET;
        end
        else
        begin
            if (wr_div && hi_en && !frozen)
            begin
                recover_on_irq <= wd[ROI_BIT];
                fast_rc_postscaler <= wd[FAST_RC_POSTSCALER_LSB +: 3];
                if (!reduce_ratio_enable)
                begin
                    doze <= wd[DOZE_LSB +: 3];
                end
                if (!wd[REDUCE_RATIO_ENABLE_BIT])
                begin
                    reduce_ratio_enable <= 1'b0;
                end
                else if (reduce_ratio_enable || wd[DOZE_LSB +: 3] != DOZE_ONE)
                begin
                    // Uses the ratio in force after this write
                    if (reduce_ratio_enable ? doze != DOZE_ONE : 1'b1)
                    begin
                        reduce_ratio_enable <= 1'b1;
                    end
                end
            end
            if (wr_div && lo_en && !frozen && wd[PRE_LSB +: 4] >= PRE_MIN
                && wd[PRE_LSB +: 4] <= PRE_MAX)
            begin
                loop_prescaler <= wd[PRE_LSB +: 4];
            end
            if (wr_fbd && lo_en && !frozen)
            begin
                fbd <= wd[7:0];
            end
            if (irq_event && recover_on_irq)
            begin
                reduce_ratio_enable <= 1'b0;
            end
        end
    end

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr[7:0])
                OSC_SELECT_CONTROL_ADDR[7:0]:
                    s_axi_rdata <= {16'h0000, 1'b0, current_source_sel, 1'b0,
                        requested_source_sel, clock_config_freeze, 1'b0,
                        loop_enabled && (loop_locked || loop_timer_done),
                        1'b0, clock_fail_flag, 2'b00, source_switch_request};
                CLOCK_DIVIDER_CONTROL_ADDR[7:0]:
                    s_axi_rdata <= {16'h0000, recover_on_irq, doze, reduce_ratio_enable,
                        fast_rc_postscaler, 4'h0, loop_prescaler};
                PLL_FEEDBACK_DIVIDER_ADDR[7:0]:
                    s_axi_rdata <= {24'h00_0000, fbd};
                UNLOCK_ADDR[7:0]:
                    s_axi_rdata <= 32'h0000_0000;
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign active_source = current_source_sel;
    assign loop_feedback_divisor = fbd;
    // Doze 1:1 unless enabled
    assign doze_ratio = reduce_ratio_enable ? doze : DOZE_ONE;
    assign doze_period = 8'((9'd1 << doze_ratio) - 9'd1);

    clock_ratio_divider #(
        .CNT_W(8)
    ) u_doze_div (
        .clk(clk),
        .resetn(resetn),
        .period_m1(doze_period),
        .tick(cpu_clock_tick)
    );
endmodule

// ==== sim/secondary_osc_switch_ctrl_props.sv ====
`timescale 1ns/1ns
module secondary_osc_switch_ctrl_props
    import osc_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic fail_safe_monitor,
    input wire logic osc_fail_trap,
    input wire logic [3:0] loop_prescaler,
    input wire logic [2:0] doze_ratio,
    input wire logic reduce_ratio_enable,
    input wire logic cpu_clock_tick
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence bad_read;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr > UNLOCK_ADDR);
    endsequence
    sequence err_answer;
        s_axi_rvalid && (s_axi_rresp == RESP_SLVERR) && (s_axi_rdata == 32'h0000_0000);
    endsequence
    a_unmapped_err: assert property (bad_read |=> err_answer)
        else $error("unmapped read not refused");
    a_no_accept_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_trap_on_fail: assert property (fail_safe_monitor |-> ##[1:2] osc_fail_trap)
        else $error("clock failure did not raise trap");
    a_trap_pulse: assert property (osc_fail_trap |=> !osc_fail_trap)
        else $error("trap longer than one cycle");
    a_ratio_when_off: assert property (
        !reduce_ratio_enable |-> doze_ratio == 3'h0 ##1 cpu_clock_tick)
        else $error("ratio not 1:1 with doze off");
    a_ratio_nonzero: assert property (reduce_ratio_enable |-> doze_ratio != 3'h0)
        else $error("doze on with ratio zero");
    a_ratio_frozen: assert property (
        reduce_ratio_enable && $past(reduce_ratio_enable) |-> $stable(doze_ratio))
        else $error("ratio changed while doze on");
    a_pre_legal: assert property (loop_prescaler inside {[4'h1:4'h8]})
        else $error("prescaler holds reserved code");
endmodule

// ==== sim/secondary_osc_switch_ctrl_tb.sv ====
`timescale 1ns/1ns
module secondary_osc_switch_ctrl_tb
    import osc_ctrl_pkg::*;
;
    logic clk = '0;
    logic resetn = '0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic [3:0] loop_prescaler;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] config_source_sel = 3'h2;
    logic [2:0] active_source, fast_rc_postscaler, doze_ratio;
    logic monitor_config_bit = '0, loop_locked = '0, loop_timer_done = '0, loop_enabled = '0;
    logic fail_safe_monitor = '0, irq_event = '0, source_ready = '0;
    logic osc_fail_trap, reduce_ratio_enable, cpu_clock_tick;
    logic [7:0] loop_feedback_divisor;
    int miscompares = 0;
    int checks_done = 0;
    int traps = 0;
    logic [1:0] bresp_seen;

    secondary_osc_switch_ctrl #(.SWITCH_CYCLES(2)) secondary_osc_switch_ctrl_inst (
        .clk(clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .config_source_sel(config_source_sel),
        .monitor_config_bit(monitor_config_bit), .loop_locked(loop_locked),
        .loop_timer_done(loop_timer_done), .loop_enabled(loop_enabled),
        .fail_safe_monitor(fail_safe_monitor), .irq_event(irq_event),
        .source_ready(source_ready), .active_source(active_source),
        .osc_fail_trap(osc_fail_trap), .fast_rc_postscaler(fast_rc_postscaler),
        .loop_prescaler(loop_prescaler), .loop_feedback_divisor(loop_feedback_divisor),
        .doze_ratio(doze_ratio), .reduce_ratio_enable(reduce_ratio_enable),
        .cpu_clock_tick(cpu_clock_tick)
    );

    initial forever #5 clk = ~clk;

    always @(posedge clk)
        if (osc_fail_trap === 1'h1)
            traps++;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        logic pa;
        logic pw;
        pa = 1'h1;
        pw = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (pa || pw)
        begin
            @(posedge clk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'h1);
        bresp_seen = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(n, e, d);
    endtask

    // Key pair then the protected write
    task automatic uw(input logic [15:0] d);
        wr(UNLOCK_ADDR, UNLOCK_KEY1);
        wr(UNLOCK_ADDR, UNLOCK_KEY2);
        wr(OSC_SELECT_CONTROL_ADDR, d);
    endtask

    task automatic ticks(input int n, input logic [31:0] e);
        logic [31:0] c;
        c = 32'h0000_0000;
        repeat (n)
        begin
            @(posedge clk);
            c = c + cpu_clock_tick;
        end
        chk("tick count", e, c);
    endtask

    task automatic t_reset();
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_2200);
        rc("divider", CLOCK_DIVIDER_CONTROL_ADDR, 32'h0000_3001);
        rc("feedback", PLL_FEEDBACK_DIVIDER_ADDR, 32'h0000_0096);
        $display("t_reset done");
    endtask

    task automatic t_switch();
        wr(OSC_SELECT_CONTROL_ADDR, 16'h0001);
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_2200);
        uw(16'h0001);
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_2001);
        source_ready <= 1'h1;
        while (active_source !== 3'h0)
            @(posedge clk);
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_0000);
        // Goes through plain fast RC before the loop mode
        uw(16'h7101);
        while (active_source !== 3'h1)
            @(posedge clk);
        loop_enabled <= 1'h1;
        loop_timer_done <= 1'h1;
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_1120);
        loop_timer_done <= 1'h0;
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_1100);
        loop_locked <= 1'h1;
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_1120);
        $display("t_switch done");
    endtask

    task automatic t_fail();
        int n0;
        n0 = traps;
        fail_safe_monitor <= 1'h1;
        @(posedge clk);
        fail_safe_monitor <= 1'h0;
        repeat (3) @(posedge clk);
        chk("trap count", n0 + 1, traps);
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_1128);
        uw(16'h0100);
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_1120);
        uw(16'h0108);
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_1128);
        chk("trap count", n0 + 2, traps);
        uw(16'h0100);
        $display("t_fail done");
    endtask

    task automatic t_doze();
        wr(CLOCK_DIVIDER_CONTROL_ADDR, 16'h0801);
        rc("divider", CLOCK_DIVIDER_CONTROL_ADDR, 32'h0000_0001);
        wr(CLOCK_DIVIDER_CONTROL_ADDR, 16'h5801);
        rc("divider", CLOCK_DIVIDER_CONTROL_ADDR, 32'h0000_5801);
        chk("doze ratio", 32'h0000_0005, doze_ratio);
        chk("doze enable", 32'h0000_0001, reduce_ratio_enable);
        ticks(64, 32'h0000_0002);
        wr(CLOCK_DIVIDER_CONTROL_ADDR, 16'h2801);
        rc("divider", CLOCK_DIVIDER_CONTROL_ADDR, 32'h0000_5801);
        wr(CLOCK_DIVIDER_CONTROL_ADDR, 16'hD801);
        irq_event <= 1'h1;
        @(posedge clk);
        irq_event <= 1'h0;
        rc("divider", CLOCK_DIVIDER_CONTROL_ADDR, 32'h0000_D001);
        chk("doze ratio", 32'h0000_0000, doze_ratio);
        chk("doze enable", 32'h0000_0000, reduce_ratio_enable);
        ticks(8, 32'h0000_0008);
        wr(CLOCK_DIVIDER_CONTROL_ADDR, 16'h07F9);
        rc("divider", CLOCK_DIVIDER_CONTROL_ADDR, 32'h0000_0701);
        chk("postscaler", 32'h0000_0007, fast_rc_postscaler);
        wr(CLOCK_DIVIDER_CONTROL_ADDR, 16'h0008);
        chk("prescaler", 32'h0000_0008, loop_prescaler);
        $display("t_doze done");
    endtask

    task automatic t_freeze();
        logic [31:0] d;
        logic [1:0] r;
        monitor_config_bit <= 1'h1;
        uw(16'h0180);
        rc("select", OSC_SELECT_CONTROL_ADDR, 32'h0000_11A0);
        wr(CLOCK_DIVIDER_CONTROL_ADDR, 16'h0003);
        rc("divider", CLOCK_DIVIDER_CONTROL_ADDR, 32'h0000_0008);
        wr(PLL_FEEDBACK_DIVIDER_ADDR, 16'h0020);
        rc("feedback", PLL_FEEDBACK_DIVIDER_ADDR, 32'h0000_0096);
        monitor_config_bit <= 1'h0;
        wr(PLL_FEEDBACK_DIVIDER_ADDR, 16'h0020);
        chk("feedback", 32'h0000_0020, loop_feedback_divisor);
        chk("write resp", 32'h0000_0000, bresp_seen);
        rd(32'h0000_0010, d, r);
        chk("unmapped data", 32'h0000_0000, d);
        chk("unmapped resp", 32'h0000_0002, r);
        wr(32'h0000_0010, 16'h0000);
        chk("unmapped wresp", 32'h0000_0002, bresp_seen);
        $display("t_freeze done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        repeat (2) @(posedge clk);
        t_reset();
        t_switch();
        t_fail();
        t_doze();
        t_freeze();
        final_report();
    end
endmodule

bind secondary_osc_switch_ctrl secondary_osc_switch_ctrl_props
    secondary_osc_switch_ctrl_props_inst (
    .clk(clk), .resetn(resetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
    .s_axi_rdata(s_axi_rdata), .fail_safe_monitor(fail_safe_monitor),
    .osc_fail_trap(osc_fail_trap), .loop_prescaler(loop_prescaler),
    .doze_ratio(doze_ratio), .reduce_ratio_enable(reduce_ratio_enable),
    .cpu_clock_tick(cpu_clock_tick)
);
